// *** rtl/ltiu_pkg.sv ***
package ltiu_pkg;

  // ---------------------------------------------------------------
  // Register selectors on the control register port.
  // ---------------------------------------------------------------
  localparam logic [6:0] CNT_NUM = 7'h2c;
  localparam logic [6:0] MATCH_NUM = 7'h01;
  localparam logic [6:0] TVEC_NUM = 7'h48;
  localparam logic [6:0] IVR_NUM = 7'h60;
  localparam logic [6:0] EOI_NUM = 7'h61;
  localparam logic [6:0] LRRF_NUM = 7'h62;
  localparam logic [6:0] LRRS_NUM = 7'h63;

  // ---------------------------------------------------------------
  // Field positions and values.
  // ---------------------------------------------------------------
  localparam int MASK_BIT = 16;
  localparam int VEC_W = 8;
  localparam int NVEC = 256;
  localparam logic [7:0] SPURIOUS_VEC = 8'h0f;
  localparam logic [7:0] LEGACY_VEC = 8'h00;
  localparam logic [63:0] CNT_RESET = 64'h0;
  localparam logic [63:0] MATCH_RESET = 64'h0;
  localparam logic [63:0] TVEC_RESET = 64'h0000000000010000;
  localparam logic [63:0] LRR_RESET = 64'h0000000000010000;

  // ---------------------------------------------------------------
  // Processor interrupt block layout.
  // ---------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int UPPER_HALF_BIT = 20;
  localparam int DEST_SHIFT = 4;
  localparam logic [20:0] INTA_OFS = 21'h1e0000;
  localparam int TICK_RATIO = 1;

  typedef enum logic [1:0] {
    LTIU_SZ_1 = 2'h0,
    LTIU_SZ_2 = 2'h1,
    LTIU_SZ_4 = 2'h2,
    LTIU_SZ_8 = 2'h3
  } ltiu_size_e;

  typedef enum logic {
    LTIU_INTA_IDLE = 1'b0,
    LTIU_INTA_WAIT = 1'b1
  } ltiu_inta_e;

  typedef struct packed {
    logic valid;
    logic is_ar;
    logic write;
    logic [6:0] num;
    logic [63:0] wdata;
  } ltiu_cr_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic uc;
    ltiu_size_e size;
    logic [20:0] addr;
    logic [63:0] wdata;
  } ltiu_mem_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] local_id;
    logic [7:0] extended_dest_id;
    logic [63:0] cmd;
  } ltiu_ipi_s;

endpackage

// *** rtl/ltiu_top.sv ***
`timescale 1ns/10ps
module ltiu_top #(
  parameter int TICK_RATIO = ltiu_pkg::TICK_RATIO
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire ltiu_pkg::ltiu_cr_req_s cr_req_i,
  output ltiu_pkg::ltiu_mem_req_s unused_o,
  output logic [63:0] cr_rdata_o,
  output logic cr_rvalid_o,
  input wire ltiu_pkg::ltiu_mem_req_s mem_req_i,
  output logic ld_valid_o,
  output logic [63:0] ld_data_o,
  output logic fault_o,
  output ltiu_pkg::ltiu_ipi_s ipi_o,
  output logic inta_req_o,
  input wire logic inta_ack_i,
  input wire logic [7:0] inta_vec_i,
  input wire logic ipi_in_valid_i,
  input wire logic [7:0] ipi_in_vec_i,
  input wire logic local_irq_pin_first_i,
  input wire logic local_irq_pin_second_i,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Finds the highest set vector.
  // ---------------------------------------------------------------
  function automatic logic [8:0] highest(input logic [255:0] v);
    logic [8:0] r;
    r = 9'h0;
    for (int i = 0; i < 256; i++)
    begin
      if (v[i])
      begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  logic [63:0] time_count, next_time_count;
  logic [63:0] time_match, next_time_match;
  logic [63:0] time_vector, next_time_vector;
  logic [63:0] local_redirect_first, next_local_redirect_first;
  logic [63:0] local_redirect_second, next_local_redirect_second;
  logic [255:0] irr, next_irr;
  logic [255:0] isr, next_isr;
  logic [31:0] div, next_div;
  logic [2:0] pin_a_sync, pin_b_sync;
  logic [63:0] next_cr_rdata;
  logic next_cr_rvalid, next_ld_valid, next_fault, next_irq;
  logic [63:0] next_ld_data;
  ltiu_pkg::ltiu_ipi_s next_ipi;
  ltiu_pkg::ltiu_inta_e inta_st, next_inta_st;
  logic tick, count_wr, timer_hit, rise_a, rise_b, ivr_rd, eoi_wr;
  logic [63:0] count_inc;
  logic [8:0] irr_hi, isr_hi;
  logic cand_ok;
  logic in_deliv, good_ipi, bad_ipi, inta_ld;

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pin_a_sync <= 3'h0;
      pin_b_sync <= 3'h0;
    end
    else
    begin
      pin_a_sync <= {pin_a_sync[1:0], local_irq_pin_first_i};
      pin_b_sync <= {pin_b_sync[1:0], local_irq_pin_second_i};
    end
  end

  // ---------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------
  always_comb
  begin
    tick = (div == 32'(TICK_RATIO - 1));
    next_div = tick ? 32'h0 : div + 32'h1;
    count_inc = time_count + 64'h1;
    count_wr = cr_req_i.valid && cr_req_i.write && cr_req_i.is_ar && cr_req_i.num == ltiu_pkg::CNT_NUM;
    ivr_rd = cr_req_i.valid && !cr_req_i.write && !cr_req_i.is_ar && cr_req_i.num == ltiu_pkg::IVR_NUM;
    eoi_wr = cr_req_i.valid && cr_req_i.write && !cr_req_i.is_ar && cr_req_i.num == ltiu_pkg::EOI_NUM;
    // Comparison is made on the incremented value only.
    timer_hit = tick && !count_wr && count_inc == time_match && !time_vector[ltiu_pkg::MASK_BIT];
    rise_a = pin_a_sync[1] && !pin_a_sync[2] && !local_redirect_first[ltiu_pkg::MASK_BIT];
    rise_b = pin_b_sync[1] && !pin_b_sync[2] && !local_redirect_second[ltiu_pkg::MASK_BIT];
    irr_hi = highest(irr);
    isr_hi = highest(isr);
    cand_ok = irr_hi[8] && (!isr_hi[8] || irr_hi[7:0] > isr_hi[7:0]);

    next_time_count = tick ? count_inc : time_count;
    next_time_match = time_match;
    next_time_vector = time_vector;
    next_local_redirect_first = local_redirect_first;
    next_local_redirect_second = local_redirect_second;
    next_irr = irr;
    next_isr = isr;
    next_cr_rdata = 64'h0;
    next_cr_rvalid = cr_req_i.valid && !cr_req_i.write;
    if (cr_req_i.valid && cr_req_i.write)
    begin
      if (count_wr)
      begin
        next_time_count = cr_req_i.wdata;
      end
      else if (!cr_req_i.is_ar)
      begin
        unique case (cr_req_i.num)
          ltiu_pkg::MATCH_NUM: next_time_match = cr_req_i.wdata;
          ltiu_pkg::TVEC_NUM: next_time_vector = cr_req_i.wdata;
          ltiu_pkg::LRRF_NUM: next_local_redirect_first = cr_req_i.wdata;
          ltiu_pkg::LRRS_NUM: next_local_redirect_second = cr_req_i.wdata;
          default: next_time_match = time_match;
        endcase
      end
    end
    if (eoi_wr && isr_hi[8])
    begin
      next_isr[isr_hi[7:0]] = 1'b0;
    end
    if (cr_req_i.valid && !cr_req_i.write)
    begin
      if (cr_req_i.is_ar)
      begin
        next_cr_rdata = (cr_req_i.num == ltiu_pkg::CNT_NUM) ? time_count : 64'h0;
      end
      else
      begin
        unique case (cr_req_i.num)
          ltiu_pkg::MATCH_NUM: next_cr_rdata = time_match;
          ltiu_pkg::TVEC_NUM: next_cr_rdata = time_vector;
          ltiu_pkg::LRRF_NUM: next_cr_rdata = local_redirect_first;
          ltiu_pkg::LRRS_NUM: next_cr_rdata = local_redirect_second;
          ltiu_pkg::IVR_NUM: next_cr_rdata = {56'h0, cand_ok ? irr_hi[7:0] : ltiu_pkg::SPURIOUS_VEC};
          default: next_cr_rdata = 64'h0;
        endcase
      end
    end
    if (ivr_rd && cand_ok)
    begin
      next_irr[irr_hi[7:0]] = 1'b0;
      next_isr[irr_hi[7:0]] = 1'b1;
    end
    // Sources are applied last so a new event beats an acquire.
    if (timer_hit)
    begin
      next_irr[time_vector[7:0]] = 1'b1;
    end
    if (rise_a)
    begin
      next_irr[local_redirect_first[7:0]] = 1'b1;
    end
    if (rise_b)
    begin
      next_irr[local_redirect_second[7:0]] = 1'b1;
    end
    if (ipi_in_valid_i)
    begin
      next_irr[ipi_in_vec_i] = 1'b1;
    end
    next_irq = cand_ok;

    // Interrupt block accesses; cacheable stores do nothing.
    in_deliv = !mem_req_i.addr[ltiu_pkg::UPPER_HALF_BIT];
    good_ipi = mem_req_i.valid && mem_req_i.write && mem_req_i.uc && in_deliv
      && mem_req_i.size == ltiu_pkg::LTIU_SZ_8 && mem_req_i.addr[2:0] == 3'h0;
    bad_ipi = mem_req_i.valid && mem_req_i.write && mem_req_i.uc && in_deliv && !good_ipi;
    inta_ld = mem_req_i.valid && !mem_req_i.write && mem_req_i.uc
      && mem_req_i.size == ltiu_pkg::LTIU_SZ_1 && mem_req_i.addr == ltiu_pkg::INTA_OFS;
    next_ipi.valid = good_ipi;
    next_ipi.local_id = mem_req_i.addr[ltiu_pkg::DEST_SHIFT + 15:ltiu_pkg::DEST_SHIFT + 8];
    next_ipi.extended_dest_id = mem_req_i.addr[ltiu_pkg::DEST_SHIFT + 7:ltiu_pkg::DEST_SHIFT];
    next_ipi.cmd = mem_req_i.wdata;
    next_fault = bad_ipi;
    next_inta_st = inta_st;
    next_ld_valid = 1'b0;
    next_ld_data = 64'h0;
    unique case (inta_st)
      ltiu_pkg::LTIU_INTA_IDLE:
      begin
        if (inta_ld)
        begin
          next_inta_st = ltiu_pkg::LTIU_INTA_WAIT;
        end
        else if (mem_req_i.valid && !mem_req_i.write)
        begin
          next_ld_valid = 1'b1;
        end
      end
      ltiu_pkg::LTIU_INTA_WAIT:
      begin
        if (inta_ack_i)
        begin
          next_inta_st = ltiu_pkg::LTIU_INTA_IDLE;
          next_ld_valid = 1'b1;
          next_ld_data = {56'h0, inta_vec_i};
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      div <= 32'h0;
      time_count <= ltiu_pkg::CNT_RESET;
      time_match <= ltiu_pkg::MATCH_RESET;
      time_vector <= ltiu_pkg::TVEC_RESET;
      local_redirect_first <= ltiu_pkg::LRR_RESET;
      local_redirect_second <= ltiu_pkg::LRR_RESET;
      irr <= 256'h0;
      isr <= 256'h0;
      cr_rdata_o <= 64'h0;
      cr_rvalid_o <= 1'b0;
      ld_valid_o <= 1'b0;
      ld_data_o <= 64'h0;
      fault_o <= 1'b0;
      ipi_o <= '0;
      inta_st <= ltiu_pkg::LTIU_INTA_IDLE;
      inta_req_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      div <= next_div;
      time_count <= next_time_count;
      time_match <= next_time_match;
      time_vector <= next_time_vector;
      local_redirect_first <= next_local_redirect_first;
      local_redirect_second <= next_local_redirect_second;
      irr <= next_irr;
      isr <= next_isr;
      cr_rdata_o <= next_cr_rdata;
      cr_rvalid_o <= next_cr_rvalid;
      ld_valid_o <= next_ld_valid;
      ld_data_o <= next_ld_data;
      fault_o <= next_fault;
      ipi_o <= next_ipi;
      inta_st <= next_inta_st;
      inta_req_o <= (next_inta_st == ltiu_pkg::LTIU_INTA_WAIT);
      irq_o <= next_irq;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    unused_o <= '0;
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence s_inta_start;
    inta_ld && inta_st == ltiu_pkg::LTIU_INTA_IDLE;
  endsequence
  sequence s_inta_pending;
    inta_req_o && !ld_valid_o;
  endsequence

  property p_count_write;
    count_wr |=> time_count == $past(cr_req_i.wdata);
  endproperty
  a_count_write: assert property (p_count_write) else $error("counter write lost");
  property p_count_runs;
    tick && !count_wr |=> time_count == $past(time_count) + 64'h1;
  endproperty
  a_count_runs: assert property (p_count_runs) else $error("counter did not advance");
  property p_timer_pend;
    tick && !count_wr && count_inc == time_match && !time_vector[ltiu_pkg::MASK_BIT] |=> irr[$past(time_vector[7:0])];
  endproperty
  a_timer_pend: assert property (p_timer_pend) else $error("timer match not pending");
  property p_pin_pend;
    pin_a_sync[1] && !pin_a_sync[2] && !local_redirect_first[ltiu_pkg::MASK_BIT]
      |=> irr[$past(local_redirect_first[7:0])];
  endproperty
  a_pin_pend: assert property (p_pin_pend) else $error("pin event not pending");
  property p_ipi_send;
    good_ipi |=> ipi_o.valid && !fault_o && ipi_o.cmd == $past(mem_req_i.wdata)
      && {ipi_o.local_id, ipi_o.extended_dest_id} == $past(mem_req_i.addr[19:4]);
  endproperty
  a_ipi_send: assert property (p_ipi_send) else $error("interrupt command not sent");
  property p_bad_store;
    bad_ipi |=> fault_o && !ipi_o.valid;
  endproperty
  a_bad_store: assert property (p_bad_store) else $error("bad store not faulted");
  property p_inta_flow;
    s_inta_start |=> s_inta_pending;
  endproperty
  a_inta_flow: assert property (p_inta_flow) else $error("acknowledge cycle missing");
  property p_inta_return;
    inta_req_o && inta_ack_i |=> ld_valid_o && !inta_req_o && ld_data_o[7:0] == $past(inta_vec_i);
  endproperty
  a_inta_return: assert property (p_inta_return) else $error("vector byte not returned");
  property p_spurious;
    ivr_rd && !cand_ok |=> cr_rvalid_o && cr_rdata_o == 64'h000000000000000f;
  endproperty
  a_spurious: assert property (p_spurious) else $error("spurious vector wrong");
  property p_eoi;
    eoi_wr && isr_hi[8] |=> !isr[$past(isr_hi[7:0])];
  endproperty
  a_eoi: assert property (p_eoi) else $error("end of interrupt ignored");

endmodule

// *** verification/ltiu_legacy_ctrl_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Legacy controller answering acknowledge cycles.
// ------------------------------------------------------------
module ltiu_legacy_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic inta_req_i,
  input wire logic [3:0] delay_i,
  input wire logic [7:0] vec_i,
  output logic inta_ack_o,
  output logic [7:0] inta_vec_o
);
  initial
  begin
    inta_ack_o = 1'b0;
    inta_vec_o = 8'h00;
    forever
    begin
      @(posedge clk_sys_i);
      if (inta_req_i === 1'b1)
      begin
        repeat (delay_i) @(posedge clk_sys_i);
        inta_ack_o <= 1'b1;
        inta_vec_o <= vec_i;
        @(posedge clk_sys_i);
        inta_ack_o <= 1'b0;
        inta_vec_o <= ~vec_i;
        @(posedge clk_sys_i);
      end
    end
  end
endmodule

// *** verification/local_timer_interrupt_unit_tb_top.sv ***
`timescale 1ns/10ps
module local_timer_interrupt_unit_tb_top;
  logic clk_sys_i, reset_i, cr_rvalid_o, ld_valid_o, fault_o, inta_req_o, inta_ack_i, irq_o, pin_a, pin_b, ipi_v;
  ltiu_pkg::ltiu_cr_req_s cr_req_i;
  ltiu_pkg::ltiu_mem_req_s mem_req_i;
  ltiu_pkg::ltiu_mem_req_s unused_o;
  ltiu_pkg::ltiu_ipi_s ipi_o;
  logic [63:0] cr_rdata_o, ld_data_o, v1, v2;
  logic [7:0] inta_vec_i, dvec, ipi_vec;
  logic [3:0] dly;
  int miscompares, checked;

  ltiu_top DUT (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .cr_req_i(cr_req_i),
    .unused_o(unused_o),
    .cr_rdata_o(cr_rdata_o),
    .cr_rvalid_o(cr_rvalid_o),
    .mem_req_i(mem_req_i),
    .ld_valid_o(ld_valid_o),
    .ld_data_o(ld_data_o),
    .fault_o(fault_o),
    .ipi_o(ipi_o),
    .inta_req_o(inta_req_o),
    .inta_ack_i(inta_ack_i),
    .inta_vec_i(inta_vec_i),
    .ipi_in_valid_i(ipi_v),
    .ipi_in_vec_i(ipi_vec),
    .local_irq_pin_first_i(pin_a),
    .local_irq_pin_second_i(pin_b),
    .irq_o(irq_o)
  );

  ltiu_legacy_ctrl_model PARTNER (
    .clk_sys_i(clk_sys_i),
    .inta_req_i(inta_req_o),
    .delay_i(dly),
    .vec_i(dvec),
    .inta_ack_o(inta_ack_i),
    .inta_vec_o(inta_vec_i)
  );

  // ------------------------------------------------------------
  // Access tasks.
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic cr_wr(input logic ar, input logic [6:0] n, input logic [63:0] d);
    @(posedge clk_sys_i);
    cr_req_i <= {1'b1, ar, 1'b1, n, d};
    @(posedge clk_sys_i);
    cr_req_i <= '0;
  endtask

  task automatic cr_rd(input logic ar, input logic [6:0] n, output logic [63:0] d);
    @(posedge clk_sys_i);
    cr_req_i <= {1'b1, ar, 1'b0, n, 64'h0};
    @(posedge clk_sys_i);
    cr_req_i <= '0;
    #1;
    chk("rvalid", 64'h1, 64'(cr_rvalid_o));
    d = cr_rdata_o;
  endtask

  task automatic rd_chk(input string s, input logic [6:0] n, input logic [63:0] e);
    logic [63:0] d;
    cr_rd(1'b0, n, d);
    chk(s, e, d);
  endtask

  task automatic mem(input logic w, input logic uc, input logic [1:0] sz, input logic [20:0] a);
    @(posedge clk_sys_i);
    mem_req_i <= {1'b1, w, uc, ltiu_pkg::ltiu_size_e'(sz), a, 64'hc0de};
    @(posedge clk_sys_i);
    mem_req_i <= '0;
    #1;
  endtask

  task automatic wt(input int which);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk_sys_i);
      #1;
      if ((which == 0 ? irq_o : ld_valid_o) === 1'b1)
        return;
    end
    $display("BAD wait %0d expected 1 seen 0", which);
    miscompares++;
    end_of_test();
  endtask

  task automatic pulse(input int which);
    @(posedge clk_sys_i);
    if (which == 0)
      pin_a <= 1'b1;
    else
      pin_b <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // ------------------------------------------------------------
  // Stimulus.
  // ------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    reset_i = 1'b1;
    cr_req_i = '0;
    mem_req_i = '0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    ipi_v = 1'b0;
    ipi_vec = 8'h00;
    dvec = 8'h42;
    dly = 4'h2;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd_chk("vector_rst", ltiu_pkg::TVEC_NUM, 64'h10000);
    rd_chk("redir_a_rst", ltiu_pkg::LRRF_NUM, 64'h10000);
    rd_chk("redir_b_rst", ltiu_pkg::LRRS_NUM, 64'h10000);
    rd_chk("match_rst", ltiu_pkg::MATCH_NUM, 64'h0);
    rd_chk("acquire_idle", ltiu_pkg::IVR_NUM, 64'h0f);
    cr_wr(1'b1, ltiu_pkg::CNT_NUM, 64'h100);
    cr_rd(1'b1, ltiu_pkg::CNT_NUM, v1);
    cr_rd(1'b1, ltiu_pkg::CNT_NUM, v2);
    chk("count_load", 64'h1, 64'(v1 >= 64'h100 && v1 < 64'h108));
    chk("count_step", v1 + 64'h2, v2);
    cr_wr(1'b0, ltiu_pkg::TVEC_NUM, 64'h10031);
    cr_wr(1'b0, ltiu_pkg::MATCH_NUM, v2 + 64'h14);
    repeat (40) @(posedge clk_sys_i);
    chk("irq_masked", 64'h0, 64'(irq_o));
    rd_chk("acquire_masked", ltiu_pkg::IVR_NUM, 64'h0f);
    cr_wr(1'b0, ltiu_pkg::TVEC_NUM, 64'h30);
    cr_rd(1'b1, ltiu_pkg::CNT_NUM, v1);
    cr_wr(1'b0, ltiu_pkg::MATCH_NUM, v1 + 64'h14);
    wt(0);
    rd_chk("acquire_timer", ltiu_pkg::IVR_NUM, 64'h30);
    rd_chk("acquire_once", ltiu_pkg::IVR_NUM, 64'h0f);
    cr_wr(1'b0, ltiu_pkg::EOI_NUM, 64'h0);
    cr_rd(1'b1, ltiu_pkg::CNT_NUM, v2);
    chk("count_past_match", 64'h1, 64'(v2 > v1 + 64'h14));
    cr_wr(1'b0, ltiu_pkg::LRRF_NUM, 64'h20);
    cr_wr(1'b0, ltiu_pkg::LRRS_NUM, 64'h10021);
    pulse(1);
    chk("pin_masked", 64'h0, 64'(irq_o));
    pulse(0);
    wt(0);
    rd_chk("acquire_pin_a", ltiu_pkg::IVR_NUM, 64'h20);
    cr_wr(1'b0, ltiu_pkg::LRRS_NUM, 64'h10);
    pulse(1);
    rd_chk("acquire_lower", ltiu_pkg::IVR_NUM, 64'h0f);
    cr_wr(1'b0, ltiu_pkg::EOI_NUM, 64'h0);
    wt(0);
    rd_chk("acquire_pin_b", ltiu_pkg::IVR_NUM, 64'h10);
    cr_wr(1'b0, ltiu_pkg::EOI_NUM, 64'h0);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys_i);
      ipi_v <= 1'b1;
      ipi_vec <= 8'h50 + 8'(i * 32);
    end
    @(posedge clk_sys_i);
    ipi_v <= 1'b0;
    wt(0);
    rd_chk("acquire_high", ltiu_pkg::IVR_NUM, 64'h70);
    rd_chk("acquire_low_held", ltiu_pkg::IVR_NUM, 64'h0f);
    cr_wr(1'b0, ltiu_pkg::EOI_NUM, 64'h0);
    wt(0);
    rd_chk("acquire_low", ltiu_pkg::IVR_NUM, 64'h50);
    cr_wr(1'b0, ltiu_pkg::EOI_NUM, 64'h0);
    mem(1'b1, 1'b1, 2'h3, {1'b0, 8'h5a, 8'ha5, 4'h0});
    chk("ipi_valid", 64'h1, 64'(ipi_o.valid));
    chk("ipi_dest", 64'h5aa5, 64'({ipi_o.local_id, ipi_o.extended_dest_id}));
    chk("ipi_cmd", 64'hc0de, ipi_o.cmd);
    mem(1'b1, 1'b1, 2'h3, {1'b0, 8'h5a, 8'ha5, 4'h4});
    chk("fault_misaligned", 64'h1, 64'({ipi_o.valid, fault_o}));
    mem(1'b1, 1'b1, 2'h2, {1'b0, 8'h5a, 8'ha5, 4'h0});
    chk("fault_narrow", 64'h1, 64'({ipi_o.valid, fault_o}));
    mem(1'b1, 1'b0, 2'h3, {1'b0, 8'h5a, 8'ha5, 4'h0});
    chk("cached_store", 64'h0, 64'({ipi_o.valid, fault_o}));
    for (int i = 0; i < 2; i++)
    begin
      dly = 4'(i * 5);
      dvec = 8'h42 + 8'(i);
      mem(1'b0, 1'b1, 2'h0, ltiu_pkg::INTA_OFS);
      chk("inta_req", 64'h1, 64'(inta_req_o));
      wt(1);
      chk("inta_vector", 64'(dvec), 64'(ld_data_o[7:0]));
      chk("inta_done", 64'h0, 64'(inta_req_o));
    end
    chk("spare_out", 64'h0, 64'(unused_o != '0));
    end_of_test();
  end
endmodule
